// *** dv/file_regs_model.sv ***
`timescale 1ns/1ps
module file_regs_model
  import exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic [ADDR_W-1:0] i_raddr,
  input wire logic i_we,
  input wire logic [ADDR_W-1:0] i_waddr,
  input wire logic [DATA_W-1:0] i_wdata,
  output logic [DATA_W-1:0] o_rdata
);
  // Combinational read, clocked write
  logic [DATA_W-1:0] mem [32];
  assign o_rdata = mem[i_raddr];
  always @(posedge i_clk) begin
    if (i_we) mem[i_waddr] <= i_wdata;
  end
endmodule : file_regs_model

// *** dv/inc_skip_or_move_exec_tb.sv ***
`timescale 1ns/1ps
module inc_skip_or_move_exec_tb;
  import exec_pkg::*;
  typedef struct {logic [11:0] ins; logic [7:0] fv, acc, wd; logic z, we, sk;} row_t;
  logic clk = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, we, zero, skip, nop_slot;
  logic [11:0] instr = 12'h000;
  logic [7:0] rdata, wdata, acc;
  logic [4:0] raddr, waddr;
  int mismatches = 0, n_tests = 0, cycles = 0;
  // Word, file value, acc, write data, zero, write, skip
  row_t rows [11] = '{
    '{12'h202, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0, 1'b0},
    '{12'hD35, 8'h00, 8'h35, 8'h00, 1'b0, 1'b0, 1'b0},
    '{12'h124, 8'h40, 8'h35, 8'h75, 1'b0, 1'b1, 1'b0},
    '{12'h105, 8'h80, 8'hB5, 8'h00, 1'b0, 1'b0, 1'b0},
    '{12'h226, 8'h00, 8'hB5, 8'h00, 1'b1, 1'b1, 1'b0},
    '{12'h3C7, 8'h10, 8'h11, 8'h00, 1'b1, 1'b0, 1'b0},
    '{12'h3E8, 8'h41, 8'h11, 8'h42, 1'b1, 1'b1, 1'b0},
    '{12'h209, 8'h20, 8'h20, 8'h00, 1'b0, 1'b0, 1'b0},
    '{12'h3C3, 8'hFF, 8'h00, 8'h00, 1'b0, 1'b0, 1'b1},
    '{12'hDFF, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0},
    '{12'h000, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0}};

  always #5 clk = ~clk;

  inc_skip_or_move_exec i_inc_skip_or_move_exec (.i_clk(clk), .i_sys_rst(sys_rst),
    .i_instr(instr), .i_instr_valid(instr_valid), .i_file_rdata(rdata),
    .o_file_raddr(raddr), .o_file_we(we), .o_file_waddr(waddr), .o_file_wdata(wdata),
    .o_acc(acc), .o_zero(zero), .o_skip(skip), .o_nop_slot(nop_slot));

  file_regs_model i_file_regs_model (.i_clk(clk), .i_raddr(raddr), .i_we(we),
    .i_waddr(waddr), .i_wdata(wdata), .o_rdata(rdata));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1

  task automatic issue(input logic [11:0] w);
    @(posedge clk) #1 instr = w;
    instr_valid = 1'b1;
    @(posedge clk) #1 instr_valid = 1'b0;
    @(posedge clk) #1;
  endtask : issue

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 400) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      i_file_regs_model.mem[rows[i].ins[4:0]] = rows[i].fv;
      issue(rows[i].ins);
      chk8(acc, rows[i].acc);
      chk1(zero, rows[i].z);
      chk1(we, rows[i].we);
      if (rows[i].we) begin
        chk8(wdata, rows[i].wd);
        chk8({3'h0, waddr}, {3'h0, rows[i].ins[4:0]});
      end
      chk1(skip, rows[i].sk);
      $display("row %0d done", i);
    end
    // Back-to-back skip squashes the next word
    i_file_regs_model.mem[10] = 8'hFF;
    @(posedge clk) #1 instr = 12'h3EA;
    instr_valid = 1'b1;
    @(posedge clk) #1 instr = 12'hDFF;
    @(posedge clk) #1 instr_valid = 1'b0;
    chk1(skip, 1'b1);
    chk1(nop_slot, 1'b1);
    chk8(wdata, 8'h00);
    chk8({3'h0, raddr}, 8'h0A);
    @(posedge clk) #1;
    chk1(nop_slot, 1'b0);
    chk8(acc, 8'h00);
    chk1(zero, 1'b0);
    $display("squash test done");
    // Reset in mid-run, then zero from literal OR
    issue(12'hD5A);
    chk8(acc, 8'h5A);
    sys_rst = 1'b1;
    #1;
    chk8(acc, 8'h00);
    chk1(zero, 1'b0);
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    issue(12'hD00);
    chk1(zero, 1'b1);
    chk8(acc, 8'h00);
    $display("reset test done");
    final_report();
  end
endmodule : inc_skip_or_move_exec_tb

// *** inc/alu_if.sv ***
`timescale 1ns/1ps
interface alu_if;
  import exec_pkg::*;
  alu_op_t op;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] result;
  logic zero;
  modport user (output op, output a, output b, input result, input zero);
  modport unit (input op, input a, input b, output result, output zero);
endinterface : alu_if

// *** inc/exec_pkg.sv ***
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int INSTR_W = 12;

  // Instruction field positions
  localparam int DEST_BIT = 5;
  localparam int OPC6_LSB = 6;
  localparam int OPC4_LSB = 8;

  // Opcode patterns
  localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h08;
  localparam logic [3:0] OPC_OR_LIT = 4'hD;

  // Reset values and constants
  localparam logic [INSTR_W-1:0] NOP_WORD = 12'h000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 5'h00;
  localparam logic ZERO_RESET = 1'b0;

  typedef enum logic [1:0] {ALU_PASS, ALU_INC, ALU_OR} alu_op_t;

endpackage : exec_pkg

// *** rtl/exec_alu.sv ***
`timescale 1ns/1ps
module exec_alu
  import exec_pkg::*;
(
  alu_if.unit port
);

  always_comb begin
    unique case (port.op)
      ALU_INC: port.result = port.a + DATA_ONE;
      ALU_OR: port.result = port.a | port.b;
      ALU_PASS: port.result = port.a;
      default: port.result = port.a;
    endcase
    // Zero on an all-clear 8-bit result
    port.zero = (port.result == DATA_ZERO);
  end

endmodule : exec_alu

// *** rtl/inc_skip_or_move_exec.sv ***
`timescale 1ns/1ps
module inc_skip_or_move_exec
  import exec_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [INSTR_W-1:0] i_instr,
  input wire logic i_instr_valid,
  input wire logic [DATA_W-1:0] i_file_rdata,
  output logic [ADDR_W-1:0] o_file_raddr,
  output logic o_file_we,
  output logic [ADDR_W-1:0] o_file_waddr,
  output logic [DATA_W-1:0] o_file_wdata,
  output logic [DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_skip,
  output logic o_nop_slot
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode stage
  logic [INSTR_W-1:0] dec_instr_q, dec_instr_d;
  logic dec_valid_q, dec_valid_d;
  logic dec_squash_q, dec_squash_d;
  logic squash_pend_q, squash_pend_d;
  logic [ADDR_W-1:0] raddr_q, raddr_d;
  logic skip_now;

  always_comb begin
    dec_instr_d = dec_instr_q;
    dec_valid_d = 1'b0;
    dec_squash_d = 1'b0;
    squash_pend_d = squash_pend_q;
    raddr_d = raddr_q;
    if (i_instr_valid) begin
      if (skip_now || squash_pend_q) begin
        // Prefetched word dropped, slot runs as a no-op
        dec_instr_d = NOP_WORD;
        dec_squash_d = 1'b1;
        squash_pend_d = 1'b0;
      end else begin
        dec_instr_d = i_instr;
        dec_valid_d = 1'b1;
        raddr_d = i_instr[ADDR_W-1:0];
      end
    end else if (skip_now) begin
      squash_pend_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dec_instr_q <= NOP_WORD;
      dec_valid_q <= 1'b0;
      dec_squash_q <= 1'b0;
      squash_pend_q <= 1'b0;
      raddr_q <= ADDR_RESET;
    end else begin
      dec_instr_q <= dec_instr_d;
      dec_valid_q <= dec_valid_d;
      dec_squash_q <= dec_squash_d;
      squash_pend_q <= squash_pend_d;
      raddr_q <= raddr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute stage
  logic is_inc, is_orl, is_orf, is_mov, dest_file;
  logic [DATA_W-1:0] exec_lit;
  logic [DATA_W-1:0] acc_q, acc_d, wdata_q, wdata_d;
  logic zero_q, zero_d, we_q, we_d, skip_q, skip_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;

  alu_if alu ();

  exec_alu u_alu (
    .port(alu)
  );

  assign is_inc = dec_valid_q && (dec_instr_q[INSTR_W-1:OPC6_LSB] == OPC_INC_SKIP);
  assign is_orf = dec_valid_q && (dec_instr_q[INSTR_W-1:OPC6_LSB] == OPC_OR_FILE);
  assign is_mov = dec_valid_q && (dec_instr_q[INSTR_W-1:OPC6_LSB] == OPC_MOVE_FILE);
  assign is_orl = dec_valid_q && (dec_instr_q[INSTR_W-1:OPC4_LSB] == OPC_OR_LIT);
  assign dest_file = dec_instr_q[DEST_BIT];
  assign exec_lit = dec_instr_q[DATA_W-1:0];
  assign skip_now = is_inc && alu.zero;

  always_comb begin
    alu.op = ALU_PASS;
    alu.a = i_file_rdata;
    alu.b = acc_q;
    if (is_inc) begin
      alu.op = ALU_INC;
    end else if (is_orl) begin
      alu.op = ALU_OR;
      alu.a = acc_q;
      alu.b = exec_lit;
    end else if (is_orf) begin
      alu.op = ALU_OR;
    end
  end

  always_comb begin
    acc_d = acc_q;
    zero_d = zero_q;
    we_d = 1'b0;
    waddr_d = waddr_q;
    wdata_d = wdata_q;
    skip_d = skip_now;
    if (is_orl) begin
      acc_d = alu.result;
      zero_d = alu.zero;
    end else if (is_inc || is_orf || is_mov) begin
      if (dest_file) begin
        we_d = 1'b1;
        waddr_d = raddr_q;
        wdata_d = alu.result;
      end else begin
        acc_d = alu.result;
      end
      if (!is_inc) begin
        zero_d = alu.zero;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      acc_q <= ACC_RESET;
      zero_q <= ZERO_RESET;
      we_q <= 1'b0;
      waddr_q <= ADDR_RESET;
      wdata_q <= DATA_ZERO;
      skip_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      zero_q <= zero_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      skip_q <= skip_d;
    end
  end

  assign o_file_raddr = raddr_q;
  assign o_file_we = we_q;
  assign o_file_waddr = waddr_q;
  assign o_file_wdata = wdata_q;
  assign o_acc = acc_q;
  assign o_zero = zero_q;
  assign o_skip = skip_q;
  assign o_nop_slot = dec_squash_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  inc_acc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_inc && !dest_file |=> o_acc == $past(i_file_rdata) + DATA_ONE && !o_file_we)
    else $error("increment to accumulator wrong");

  inc_file_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_inc && dest_file |=> o_file_we && o_file_wdata == $past(i_file_rdata) + DATA_ONE
      && $stable(o_acc))
    else $error("increment write-back wrong");

  inc_flag_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_inc |=> $stable(o_zero))
    else $error("increment changed zero flag");

  skip_cond_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_inc |=> o_skip == ($past(i_file_rdata) == 8'hFF))
    else $error("skip decision wrong");

  skip_squash_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    skip_now && i_instr_valid |=> o_nop_slot && !dec_valid_q ##1 !o_file_we && !o_skip)
    else $error("prefetched word not squashed");

  skip_pend_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    squash_pend_q && i_instr_valid |=> o_nop_slot && !dec_valid_q && $stable(o_file_raddr))
    else $error("pending squash not applied");

  nop_once_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_nop_slot |=> !o_nop_slot)
    else $error("no-op slot longer than one cycle");

  orl_acc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_orl |=> o_acc == ($past(acc_q) | $past(exec_lit)) && !o_file_we)
    else $error("literal OR wrong");

  orl_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_orl |=> o_zero == (o_acc == DATA_ZERO))
    else $error("literal OR zero flag wrong");

  orf_dest_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_orf && dest_file |=> o_file_we && $stable(o_acc)
      && o_file_wdata == ($past(acc_q) | $past(i_file_rdata))
      && o_zero == (o_file_wdata == DATA_ZERO))
    else $error("register OR write-back wrong");

  orf_acc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_orf && !dest_file |=> !o_file_we && o_acc == ($past(acc_q) | $past(i_file_rdata))
      && o_zero == (o_acc == DATA_ZERO))
    else $error("register OR to accumulator wrong");

  mov_acc_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_mov && !dest_file |=> o_acc == $past(i_file_rdata) && !o_file_we)
    else $error("move to accumulator wrong");

  mov_zero_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    is_mov && dest_file |=> o_file_wdata == $past(i_file_rdata)
      && o_file_waddr == $past(raddr_q) && o_zero == ($past(i_file_rdata) == DATA_ZERO))
    else $error("move zero test wrong");

  idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !(is_inc || is_orl || is_orf || is_mov) |=> !o_file_we && !o_skip && $stable(o_zero)
      && $stable(o_acc))
    else $error("idle slot changed state");

endmodule : inc_skip_or_move_exec
